// ---- common/pmi_consts.svh ----
// Constants for the MAC-side port of the PHY data interface
// Assumes a 100 MHz core clock
`ifndef PMI_CONSTS_SVH
`define PMI_CONSTS_SVH
`define PMI_CLK_MHZ 100
// Receive clock half periods in core cycles (10M, 100M, 1000M)
`define PMI_RXCLK_HALF_10M 16'd20
`define PMI_RXCLK_HALF_100M 16'd2
`define PMI_RXCLK_HALF_1000M 16'd1
// Serial clock half period in core cycles
`define PMI_SCLK_HALF 16'd1
`define PMI_NIB_W 4
`define PMI_SER_LEN 4'd9
`endif

// ---- common/pmi_pkg.sv ----
// Types for the MAC-side port of the PHY data interface
// Assumes pmi_consts.svh is on the include path
package pmi_pkg;
    typedef enum logic [1:0] {PMI_SPD_10, PMI_SPD_100, PMI_SPD_1000} pmi_speed_e;
    typedef enum logic {PMI_MODE_RGMII, PMI_MODE_SERIAL} pmi_mode_e;
    // Receive symbol from the line side
    typedef struct packed {
        logic [7:0] data;
        logic dv;
        logic er;
    } pmi_sym_s;
endpackage

// ---- rtl/pmi_port.sv ----
// MAC-facing data port: RGMII nibbles or serial pairs on shared pins
// Assumes all link inputs are asynchronous to clk and are synchronised here
// Overview of operation
// - In RGMII mode the transmit nibble is sampled on edges of the MAC transmit clock.
// - In RGMII mode the receive clock runs at 2.5, 25 or 50 MHz for 10, 100 or 1000 Mbps.
// - In RGMII mode the receive nibble is launched with the receive clock.
// - In serial mode a continuous differential clock pair is driven toward the MAC.
// - In serial mode input data is taken on the differential pair with its clock.
// - In serial mode output data leaves on a pair synchronous to the clock driven out.
// - In RGMII mode receive valid and error share one control line on both receive clock edges.
`timescale 1ns/1ps
`include "pmi_consts.svh"
`default_nettype none
module pmi_port (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Mode and speed selection
    input wire pmi_pkg::pmi_mode_e mode,
    input wire pmi_pkg::pmi_speed_e speed,
    // Line side receive symbol and transmit result
    input wire pmi_pkg::pmi_sym_s rx_sym,
    output pmi_pkg::pmi_sym_s tx_sym,
    output logic tx_sym_valid,
    // Transmit pins from the MAC (shared with serial input)
    input wire logic mac_sourced_tx_clock,
    input wire logic tx_ctrl,
    input wire logic tx_nibble_bit3,
    input wire logic tx_nibble_bit2,
    input wire logic tx_nibble_bit1,
    input wire logic tx_nibble_bit0,
    // Receive pins toward the MAC (shared with serial output)
    output logic rx_clk,
    output logic rx_ctrl,
    output logic rx_nibble_bit3,
    output logic rx_nibble_bit2,
    output logic rx_nibble_bit1,
    output logic rx_nibble_bit0,
    output logic rx_pins_oe
);
    import pmi_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [6:0] in_s1_r, in_s2_r, in_s3_r;
    wire [6:0] in_raw = {mac_sourced_tx_clock, tx_ctrl, tx_nibble_bit3, tx_nibble_bit2,
        tx_nibble_bit1, tx_nibble_bit0, 1'b0};
    // Third stage is only the edge detectors' history
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_s1_r <= 7'h00;
            in_s2_r <= 7'h00;
            in_s3_r <= 7'h00;
        end else begin
            in_s1_r <= in_raw;
            in_s2_r <= in_s1_r;
            in_s3_r <= in_s2_r;
        end
    end
    wire serial_mode = (mode == PMI_MODE_SERIAL);
    wire txc_now = in_s2_r[6];
    wire txc_rise = txc_now & ~in_s3_r[6];
    wire txc_fall = ~txc_now & in_s3_r[6];
    // Link clock edges show two to three core cycles late
    wire [3:0] tx_nib = in_s2_r[4:1];
    wire tx_ctl = in_s2_r[5];
    // Serial data pair: bit1 carries positive, bit0 negative leg
    wire ser_in_pos = in_s2_r[2];
    wire ser_in_neg = in_s2_r[1];
    // Differential leg pair to one bit: positive above negative
    function automatic logic diff_bit(input logic pos, input logic neg);
        diff_bit = pos & ~neg;
    endfunction
    wire ser_in_bit = diff_bit(ser_in_pos, ser_in_neg);

    ////////////////////////////////////////////////////////////////////
    // RGMII transmit: low nibble and enable on rise, high nibble and error on fall
    // Transmit clock half period must exceed three core cycles
    logic [3:0] lo_nib_r;
    logic tx_en_r;
    pmi_sym_s tx_sym_r;
    logic tx_sym_valid_r;
    // Serial receive shift register
    logic [9:0] ser_shift_r;
    logic [3:0] ser_cnt_r;
    // Word counter free-runs from reset; no frame alignment
    wire ser_clk_rise = txc_rise; // Clock that accompanies the serial input
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lo_nib_r <= 4'h0;
            tx_en_r <= 1'b0;
            tx_sym_r <= '0;
            tx_sym_valid_r <= 1'b0;
            ser_shift_r <= 10'h000;
            ser_cnt_r <= 4'h0;
        end else begin
            tx_sym_valid_r <= 1'b0;
            if (!serial_mode) begin
                if (txc_rise) begin
                    lo_nib_r <= tx_nib;
                    tx_en_r <= tx_ctl;
                end
                if (txc_fall) begin
                    tx_sym_r.data <= {tx_nib, lo_nib_r};
                    tx_sym_r.dv <= tx_en_r;
                    tx_sym_r.er <= tx_en_r ^ tx_ctl;
                    tx_sym_valid_r <= 1'b1;
                end
            end else if (ser_clk_rise) begin
                // Differential bit: positive above negative
                ser_shift_r <= {ser_in_bit, ser_shift_r[9:1]};
                if (ser_cnt_r == `PMI_SER_LEN) begin
                    ser_cnt_r <= 4'h0;
                    tx_sym_r.data <= ser_shift_r[9:2];
                    tx_sym_r.dv <= 1'b1;
                    tx_sym_r.er <= 1'b0;
                    tx_sym_valid_r <= 1'b1;
                end else begin
                    ser_cnt_r <= ser_cnt_r + 4'h1;
                end
            end
        end
    end
    assign tx_sym = tx_sym_r;
    assign tx_sym_valid = tx_sym_valid_r;

    ////////////////////////////////////////////////////////////////////
    // Receive clock divider
    function automatic logic [15:0] half_of(input pmi_speed_e s);
        case (s)
            PMI_SPD_10: half_of = `PMI_RXCLK_HALF_10M;
            PMI_SPD_100: half_of = `PMI_RXCLK_HALF_100M;
            default: half_of = `PMI_RXCLK_HALF_1000M;
        endcase
    endfunction
    // Serial mode always runs the fastest divide
    wire [15:0] half_cnt = serial_mode ? `PMI_SCLK_HALF : half_of(speed);
    logic [15:0] div_r;
    logic clk_out_r;
    // Tick on the last core cycle of each half period
    wire div_tick = (div_r >= half_cnt - 16'd1);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_r <= 16'h0000;
            clk_out_r <= 1'b0;
        end else if (div_tick) begin
            div_r <= 16'h0000;
            clk_out_r <= ~clk_out_r;
        end else begin
            div_r <= div_r + 16'd1;
        end
    end
    wire rx_rise = div_tick & ~clk_out_r;
    wire rx_fall = div_tick & clk_out_r;

    ////////////////////////////////////////////////////////////////////
    // Receive launch
    // Line symbol taken on each receive clock rise in RGMII mode, on every tenth fall in serial mode
    pmi_sym_s rx_hold_r;
    logic [3:0] rx_nib_r;
    logic rx_ctl_r;
    logic [9:0] ser_out_r;
    logic [3:0] ser_ocnt_r;
    logic ser_bit_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_hold_r <= '0;
            rx_nib_r <= 4'h0;
            rx_ctl_r <= 1'b0;
            ser_out_r <= 10'h000;
            ser_ocnt_r <= 4'h0;
            ser_bit_r <= 1'b0;
        end else if (!serial_mode) begin
            if (rx_rise) begin
                rx_hold_r <= rx_sym;
                rx_nib_r <= rx_sym.data[3:0];
                rx_ctl_r <= rx_sym.dv;
            end else if (rx_fall) begin
                rx_nib_r <= rx_hold_r.data[7:4];
                rx_ctl_r <= rx_hold_r.dv ^ rx_hold_r.er;
            end
        end else if (rx_fall) begin
            // Serial output changes on falling edge, stable at the rising one
            // Serial word: start 1, data LSB first, stop 0
            if (ser_ocnt_r == `PMI_SER_LEN) begin
                ser_ocnt_r <= 4'h0;
                ser_out_r <= {1'b0, rx_sym.data, 1'b1};
            end else begin
                ser_ocnt_r <= ser_ocnt_r + 4'h1;
                ser_out_r <= {1'b0, ser_out_r[9:1]};
            end
            ser_bit_r <= ser_out_r[0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared pin routing, registered
    // One register stage so every pin leaves a flip-flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_clk <= 1'b0;
            rx_ctrl <= 1'b0;
            rx_nibble_bit3 <= 1'b0;
            rx_nibble_bit2 <= 1'b0;
            rx_nibble_bit1 <= 1'b0;
            rx_nibble_bit0 <= 1'b0;
            rx_pins_oe <= 1'b0;
        end else begin
            rx_pins_oe <= 1'b1;
            // Receive clock parked low while the pins carry serial pairs
            rx_clk <= serial_mode ? 1'b0 : clk_out_r;
            rx_ctrl <= serial_mode ? 1'b0 : rx_ctl_r;
            // Bit0/1 carry serial clock pair, bit2/3 serial data pair
            rx_nibble_bit0 <= serial_mode ? clk_out_r : rx_nib_r[0];
            rx_nibble_bit1 <= serial_mode ? ~clk_out_r : rx_nib_r[1];
            rx_nibble_bit2 <= serial_mode ? ser_bit_r : rx_nib_r[2];
            rx_nibble_bit3 <= serial_mode ? ~ser_bit_r : rx_nib_r[3];
        end
    end
endmodule
`default_nettype wire

// ---- verif/pmi_port_properties.sv ----
// Timing checker for the MAC-facing data port
// Assumes mode and speed change only while reset is held
`timescale 1ns/1ps
`default_nettype none
module pmi_port_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Selection
    input wire pmi_pkg::pmi_mode_e mode,
    input wire pmi_pkg::pmi_speed_e speed,
    // Watched outputs
    input wire logic tx_sym_valid,
    input wire logic rx_clk,
    input wire logic rx_nibble_bit0,
    input wire logic rx_nibble_bit1,
    input wire logic rx_nibble_bit2,
    input wire logic rx_nibble_bit3,
    input wire logic rx_pins_oe
);
    import pmi_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire rg = mode == PMI_MODE_RGMII;
    wire ser = mode == PMI_MODE_SERIAL;
    ////////////////////////////////////////
    a_oe_after_reset: assert property (1 |=> rx_pins_oe)
        else $error("pins not enabled");
    a_rx_clk_10m: assert property (rg && speed == PMI_SPD_10 && $rose(rx_clk) |-> ##20 $fell(rx_clk))
        else $error("bad 10M half period");
    a_rx_clk_100m: assert property (rg && speed == PMI_SPD_100 && $rose(rx_clk) |-> ##2 $fell(rx_clk))
        else $error("bad 100M half period");
    a_rx_clk_1000m: assert property (rg && speed == PMI_SPD_1000 && $rose(rx_clk) |=> $fell(rx_clk))
        else $error("bad 1000M half period");
    a_serial_clk_quiet: assert property (ser |-> !rx_clk)
        else $error("receive clock runs in serial mode");
    a_serial_clk_diff: assert property (ser && rx_pins_oe && $past(rx_pins_oe) |-> rx_nibble_bit1 != rx_nibble_bit0)
        else $error("serial clock pair not complementary");
    a_serial_data_diff: assert property (ser && rx_pins_oe && $past(rx_pins_oe) |-> rx_nibble_bit3 != rx_nibble_bit2)
        else $error("serial data pair not complementary");
    a_serial_clk_runs: assert property (ser && rx_pins_oe [*3] |-> $changed(rx_nibble_bit0))
        else $error("serial clock stalled");
    a_valid_pulse: assert property (tx_sym_valid |=> !tx_sym_valid)
        else $error("transmit valid longer than one cycle");
    c_tx_symbol: cover property (tx_sym_valid);
    c_serial: cover property (ser && rx_pins_oe);
    c_slow_clock: cover property (rg && speed == PMI_SPD_10 && $rose(rx_clk));
endmodule
bind pmi_port pmi_port_properties i_props (.clk(clk), .reset(reset), .mode(mode), .speed(speed),
    .tx_sym_valid(tx_sym_valid), .rx_clk(rx_clk), .rx_nibble_bit0(rx_nibble_bit0),
    .rx_nibble_bit1(rx_nibble_bit1), .rx_nibble_bit2(rx_nibble_bit2),
    .rx_nibble_bit3(rx_nibble_bit3), .rx_pins_oe(rx_pins_oe));
`default_nettype wire

// ---- verif/pmi_mac_model.sv ----
// MAC transmit side: free-running 8 MHz clock, nibbles on both edges
// Assumes the bench holds the byte and flags it wants sent
`timescale 1ns/1ps
`default_nettype none
module pmi_mac_model (
    // Pins toward the port
    output logic mac_sourced_tx_clock,
    output logic tx_ctrl,
    output logic [3:0] tx_nibble,
    // Symbol to send
    input wire logic [7:0] tx_byte,
    input wire logic tx_en,
    input wire logic tx_er
);
    initial begin
        mac_sourced_tx_clock = 1'b0;
        tx_ctrl = 1'b0;
        tx_nibble = 4'h0;
        forever begin
            #31.25 tx_nibble = tx_byte[3:0];
            tx_ctrl = tx_en;
            #31.25 mac_sourced_tx_clock = 1'b1;
            #31.25 tx_nibble = tx_byte[7:4];
            tx_ctrl = tx_en ^ tx_er;
            #31.25 mac_sourced_tx_clock = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- verif/pmi_port_tb.sv ----
// Self-checking bench for the MAC-facing data port
// Assumes the checker is bound and the MAC model drives the transmit pins
`timescale 1ns/1ps
`default_nettype none
module pmi_port_tb;
    import pmi_pkg::*;
    logic clk, reset, tx_sym_valid, tx_en, tx_er;
    pmi_mode_e mode;
    pmi_speed_e speed;
    pmi_sym_s rx_sym, tx_sym, s;
    logic [7:0] tx_byte;
    wire mtx_clk, tx_ctrl, rx_clk, rx_ctrl, rx_pins_oe;
    wire [3:0] tx_nib, rx_nib;
    int n_fail = 0;
    int samples_checked = 0;
    logic prev, found;
    logic [39:0] bits;
    int nb;
    // Serial word on the wire, first bit in bit 0
    function automatic logic [9:0] ser_word(logic [7:0] d);
        return {1'b0, d, 1'b1};
    endfunction
    pmi_mac_model i_mac (.mac_sourced_tx_clock(mtx_clk), .tx_ctrl(tx_ctrl), .tx_nibble(tx_nib),
        .tx_byte(tx_byte), .tx_en(tx_en), .tx_er(tx_er));
    pmi_port i_dut (.clk(clk), .reset(reset), .mode(mode), .speed(speed), .rx_sym(rx_sym),
        .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid), .mac_sourced_tx_clock(mtx_clk),
        .tx_ctrl(tx_ctrl), .tx_nibble_bit3(tx_nib[3]), .tx_nibble_bit2(tx_nib[2]),
        .tx_nibble_bit1(tx_nib[1]), .tx_nibble_bit0(tx_nib[0]), .rx_clk(rx_clk),
        .rx_ctrl(rx_ctrl), .rx_nibble_bit3(rx_nib[3]), .rx_nibble_bit2(rx_nib[2]),
        .rx_nibble_bit1(rx_nib[1]), .rx_nibble_bit0(rx_nib[0]), .rx_pins_oe(rx_pins_oe));
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait on the receive clock (sel 0) or transmit valid (sel 1)
    task automatic wait_sig(bit sel, logic v);
        int i;
        @(negedge clk);
        for (i = 0; i < 300 && (sel ? tx_sym_valid : rx_clk) !== v; i++) @(negedge clk);
        if ((sel ? tx_sym_valid : rx_clk) !== v) begin
            n_fail++;
            print_verdict();
        end
    endtask
    task automatic restart(pmi_mode_e m, pmi_speed_e sp);
        @(negedge clk);
        reset = 1'b1;
        mode = m;
        speed = sp;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        chk("pins enable", 10'h1, {9'h0, rx_pins_oe});
    endtask
    ////////////////////////////////////////
    initial begin
        reset = 1'b1;
        mode = PMI_MODE_RGMII;
        speed = PMI_SPD_10;
        rx_sym = '0;
        tx_byte = 8'h00;
        tx_en = 1'b0;
        tx_er = 1'b0;
        void'($urandom(32'h1df7302d));
        for (int sp = 0; sp < 3; sp++) begin
            restart(PMI_MODE_RGMII, pmi_speed_e'(sp));
            for (int k = 0; k < 4; k++) begin
                s = (k == 0) ? 10'h3ff : 10'($urandom);
                rx_sym = s;
                wait_sig(1'b0, 1'b0);
                wait_sig(1'b0, 1'b1);
                wait_sig(1'b0, 1'b0);
                wait_sig(1'b0, 1'b1);
                chk("rx rise half", {5'h0, s.dv, s.data[3:0]}, {5'h0, rx_ctrl, rx_nib});
                wait_sig(1'b0, 1'b0);
                chk("rx fall half", {5'h0, s.dv ^ s.er, s.data[7:4]}, {5'h0, rx_ctrl, rx_nib});
            end
        end
        for (int k = 0; k < 8; k++) begin
            tx_byte = (k == 0) ? 8'hff : 8'($urandom);
            tx_en = (k < 2) | 1'($urandom);
            tx_er = (k == 1) | 1'($urandom);
            wait_sig(1'b1, 1'b1);
            wait_sig(1'b1, 1'b1);
            chk("tx symbol", {tx_byte, tx_en, tx_er}, tx_sym);
        end
        rx_sym = {8'h5a, 1'b1, 1'b0};
        tx_byte = 8'h22;
        restart(PMI_MODE_SERIAL, PMI_SPD_1000);
        prev = rx_nib[0];
        repeat (6) begin
            @(negedge clk);
            chk("serial clock toggle", {9'h0, ~prev}, {9'h0, rx_nib[0]});
            chk("serial pins", {8'h0, ~rx_nib[0], ~rx_nib[2]}, {8'h0, rx_nib[1], rx_nib[3]});
            chk("rx clock parked", 10'h0, {9'h0, rx_clk});
            prev = rx_nib[0];
        end
        nb = 0;
        bits = '0;
        for (int i = 0; i < 200 && nb < 40; i++) begin
            @(negedge clk);
            if (rx_nib[0]) begin
                bits[nb] = rx_nib[2];
                nb++;
            end
        end
        found = 1'b0;
        for (int i = 0; i < 30; i++) begin
            if (bits[i +: 10] == ser_word(8'h5a)) found = 1'b1;
        end
        chk("serial frame", 10'h1, {9'h0, found});
        for (int k = 0; k < 2; k++) begin
            tx_byte = k ? 8'h11 : 8'h22;
            wait_sig(1'b1, 1'b1);
            wait_sig(1'b1, 1'b1);
            chk("serial symbol", {(k ? 8'h00 : 8'hff), 2'b10}, tx_sym);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
